// file: logic/ars_supervisor.sv
//Behaviour
//[R1] Mode resets to zero: nothing automatic
//[R2] Mode picks one of seven restart behaviours
//[R3] Behaviours coded 0,1,4,6,14,16,26 in order
//[R4] Attempt limit defaults three, restart modes only
//[R5] Each acknowledgement decrements attempt counter
//[R6] Limit zero or one: one attempt only
//[R7] Limit n: fail after nth attempt fails
//[R8] Reload counter: window, fail-ack, config change
//[R9] Wait before attempts, modes 4,6,26 only
//[R10] Watch timer from fault to success
//[R11] Watch time zero disables watch timer
//[R12] Software keeps watch time above startup sum
//[R13] Reset window starts at each success
//[R14] Too many successes in window: fail
//[R15] Ten listed fault numbers never restart
//[R16] List applies in modes 6,16,26 only
//[R17] Auto acknowledge per mode and on command
//[R18] Auto switch-on only while on command
//[R19] Success: one second fault free after magnetizing
//[R20] Undervoltage or supply loss is power failure
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ars_supervisor
#(
  parameter int TICK_CYCLES = ars_pkg::TICK_CYC
)
(
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  input  wire logic            i_hsel,
  input  wire logic [31:0]     i_haddr,
  input  wire logic [1:0]      i_htrans,
  input  wire logic            i_hwrite,
  input  wire logic [2:0]      i_hsize,
  input  wire logic [31:0]     i_hwdata,
  input  wire logic            i_hready,
  output logic      [31:0]     o_hrdata,
  output logic                 o_hreadyout,
  output logic                 o_hresp,
  input  wire ars_pkg::ars_evt_t i_evt,
  input  wire logic            i_motor_on_command,
  input  wire logic            i_manual_ack,
  input  wire logic            i_magnetization_done_flag,
  output logic                 o_auto_ack,
  output logic                 o_switch_on,
  output logic                 o_restart_fail
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [4:0]  restart_mode_sel_r;
  logic [7:0]  start_attempt_limit_r;
  logic [15:0] attempt_wait_time_r;
  logic [15:0] restart_watch_time_r;
  logic [15:0] counter_reset_window_r;
  logic [15:0] restart_suppress_list_r [ars_pkg::LIST_N];
  logic        pend_r;
  logic        wr_r;
  logic        size_ok_r;
  logic [7:0]  addr_r;
  logic        reload_r;
  logic [7:0]  cnt_r;
  logic [7:0]  succ_r;
  logic [ars_pkg::DIV_W-1:0] div_r;
  logic        tick_r;
  ars_pkg::ars_state_t st_r;
  ars_pkg::ars_state_t st_nxt;
  logic        wr_go;
  logic [31:0] rd_nxt;
  logic [ars_pkg::LIST_N-1:0] hit;
  logic [ars_pkg::TMR_N-1:0]  t_start;
  logic [ars_pkg::TMR_N-1:0]  t_stop;
  logic [ars_pkg::TMR_N-1:0]  t_busy;
  logic [ars_pkg::TMR_N-1:0]  t_done;
  logic [15:0] t_load [ars_pkg::TMR_N];
  logic        evt;
  logic        pwr;
  logic        supp;
  logic        eligible;
  logic        ack_ok;
  logic        ack_go;
  logic        succ;
  logic        fail_set;
  logic        fail_clr;
  logic [7:0]  eff_lim;
  logic        m_restart;

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state per transfer so reads never see stale writes
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_r      <= 1'b0;
      wr_r        <= 1'b0;
      size_ok_r   <= 1'b0;
      addr_r      <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else if (i_hsel && i_htrans[1] && i_hready)
    begin
      pend_r      <= 1'b1;
      wr_r        <= i_hwrite;
      size_ok_r   <= (i_hsize == 3'h2);
      addr_r      <= {i_haddr[7:2], 2'b00};
      o_hreadyout <= 1'b0;
    end
    else if (pend_r)
    begin
      pend_r      <= 1'b0;
      o_hreadyout <= 1'b1;
    end
  end

  assign wr_go = pend_r && wr_r && size_ok_r;

  // Settings registers; a mode or limit write arms a counter reload
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      restart_mode_sel_r     <= ars_pkg::MODE_RST; // R1
      start_attempt_limit_r  <= ars_pkg::LIMIT_RST; // R4
      attempt_wait_time_r    <= ars_pkg::WAIT_RST;
      restart_watch_time_r   <= ars_pkg::WATCH_RST;
      counter_reset_window_r <= ars_pkg::WINDOW_RST; // R13
      reload_r               <= 1'b0;
    end
    else
    begin
      reload_r <= wr_go && (addr_r == ars_pkg::OFS_MODE || addr_r == ars_pkg::OFS_LIMIT); // R8
      if (wr_go && addr_r == ars_pkg::OFS_MODE)
        restart_mode_sel_r <= i_hwdata[4:0];
      if (wr_go && addr_r == ars_pkg::OFS_LIMIT)
        start_attempt_limit_r <= i_hwdata[7:0];
      if (wr_go && addr_r == ars_pkg::OFS_WAIT)
        attempt_wait_time_r <= i_hwdata[15:0];
      if (wr_go && addr_r == ars_pkg::OFS_WATCH)
        restart_watch_time_r <= i_hwdata[15:0];
      if (wr_go && addr_r == ars_pkg::OFS_WINDOW)
        counter_reset_window_r <= i_hwdata[15:0];
    end
  end

  // Suppression list entries and their match against the incoming fault
  for (genvar g = 0; g < ars_pkg::LIST_N; g++)
  begin : g_list
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
      if (i_rst)
        restart_suppress_list_r[g] <= 16'h0000;
      else if (wr_go && addr_r == ars_pkg::OFS_LIST + 8'(4 * g))
        restart_suppress_list_r[g] <= i_hwdata[15:0];
    end
    assign hit[g] = i_evt.fault && (i_evt.fault_num == restart_suppress_list_r[g]); // R15
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (addr_r)
      ars_pkg::OFS_MODE:   rd_nxt[4:0] = restart_mode_sel_r;
      ars_pkg::OFS_LIMIT:  rd_nxt[7:0] = start_attempt_limit_r;
      ars_pkg::OFS_WAIT:   rd_nxt[15:0] = attempt_wait_time_r;
      ars_pkg::OFS_WATCH:  rd_nxt[15:0] = restart_watch_time_r;
      ars_pkg::OFS_WINDOW: rd_nxt[15:0] = counter_reset_window_r;
      ars_pkg::OFS_STATUS:
      begin
        rd_nxt[ars_pkg::ST_CNT_LSB +: 8]   = cnt_r;
        rd_nxt[ars_pkg::ST_SUCC_LSB +: 8]  = succ_r;
        rd_nxt[ars_pkg::ST_BUSY_LSB +: 4]  = t_busy;
        rd_nxt[ars_pkg::ST_STATE_LSB +: 3] = st_r;
        rd_nxt[ars_pkg::ST_FAIL_BIT]       = o_restart_fail;
      end
      default:
        for (int i = 0; i < ars_pkg::LIST_N; i++)
          if (addr_r == ars_pkg::OFS_LIST + 8'(4 * i))
            rd_nxt[15:0] = restart_suppress_list_r[i];
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_hrdata <= 32'h0000_0000;
    else if (pend_r && !wr_r)
      o_hrdata <= rd_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // 100 ms tick divider
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == ars_pkg::DIV_W'(TICK_CYCLES - 1));
      div_r  <= (div_r == ars_pkg::DIV_W'(TICK_CYCLES - 1)) ? '0 : div_r + 1'b1;
    end
  end

  // Wait, watch, window and proving timers
  assign t_load[ars_pkg::TMR_WAIT] = (restart_mode_sel_r == ars_pkg::MODE_PF || restart_mode_sel_r == ars_pkg::MODE_FLT
                                     || restart_mode_sel_r == ars_pkg::MODE_ON_CMD) ? attempt_wait_time_r : 16'h0000; // R9
  assign t_load[ars_pkg::TMR_WATCH]  = restart_watch_time_r;
  assign t_load[ars_pkg::TMR_WINDOW] = counter_reset_window_r;
  assign t_load[ars_pkg::TMR_PROVE]  = 16'(ars_pkg::PROVE_TICKS);

  for (genvar t = 0; t < ars_pkg::TMR_N; t++)
  begin : g_tmr
    ars_tick_timer u_tmr
    (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_tick  (tick_r),
      .i_start (t_start[t]),
      .i_stop  (t_stop[t]),
      .i_load  (t_load[t]),
      .o_busy  (t_busy[t]),
      .o_done  (t_done[t])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event classification per mode
  assign evt       = i_evt.fault || i_evt.power_fail;
  assign pwr       = i_evt.power_fail || (i_evt.fault && i_evt.fault_num == ars_pkg::FAULT_DC_UNDERVOLT); // R20
  assign supp      = (|hit) && (restart_mode_sel_r == ars_pkg::MODE_FLT || restart_mode_sel_r == ars_pkg::MODE_FLT_MAN
                     || restart_mode_sel_r == ars_pkg::MODE_ON_CMD); // R16
  assign m_restart = restart_mode_sel_r == ars_pkg::MODE_PF || restart_mode_sel_r == ars_pkg::MODE_FLT
                     || restart_mode_sel_r == ars_pkg::MODE_PF_MAN || restart_mode_sel_r == ars_pkg::MODE_FLT_MAN
                     || restart_mode_sel_r == ars_pkg::MODE_ON_CMD;
  // Power modes restart on power failure only; fault modes on any unlisted fault
  assign eligible  = ((restart_mode_sel_r == ars_pkg::MODE_FLT || restart_mode_sel_r == ars_pkg::MODE_FLT_MAN
                     || restart_mode_sel_r == ars_pkg::MODE_ON_CMD) && !supp)
                     || ((restart_mode_sel_r == ars_pkg::MODE_PF || restart_mode_sel_r == ars_pkg::MODE_PF_MAN) && pwr); // R2 R3
  assign ack_ok    = (restart_mode_sel_r == ars_pkg::MODE_ON_CMD)
                     || ((restart_mode_sel_r == ars_pkg::MODE_PF || restart_mode_sel_r == ars_pkg::MODE_FLT)
                         && i_motor_on_command)
                     || ((restart_mode_sel_r == ars_pkg::MODE_PF_MAN || restart_mode_sel_r == ars_pkg::MODE_FLT_MAN)
                         && i_manual_ack); // R17
  assign eff_lim   = (start_attempt_limit_r <= 8'h01) ? 8'h01 : start_attempt_limit_r; // R6 R7

  // Restart sequencer
  always_comb
  begin
    st_nxt   = st_r;
    ack_go   = 1'b0;
    succ     = 1'b0;
    fail_set = 1'b0;
    fail_clr = 1'b0;
    t_start  = '0;
    t_stop   = '0;
    unique case (st_r)
      ars_pkg::ARS_IDLE:
        if (evt && eligible && m_restart)
        begin
          st_nxt = ars_pkg::ARS_ACK;
          t_start[ars_pkg::TMR_WATCH] = (restart_watch_time_r != 16'h0000); // R10 R11
        end
      ars_pkg::ARS_ACK:
        if (ack_ok)
        begin
          ack_go = 1'b1; // R5
          if (cnt_r == 8'h00)
            fail_set = 1'b1; // R6 R7
          else
          begin
            st_nxt = ars_pkg::ARS_DELAY;
            t_start[ars_pkg::TMR_WAIT] = 1'b1; // R9
          end
        end
      ars_pkg::ARS_DELAY:
        if (t_done[ars_pkg::TMR_WAIT])
          st_nxt = ars_pkg::ARS_START;
      ars_pkg::ARS_START:
        if (evt)
          st_nxt = eligible ? ars_pkg::ARS_ACK : ars_pkg::ARS_IDLE;
        else if (i_magnetization_done_flag && i_motor_on_command)
        begin
          st_nxt = ars_pkg::ARS_PROVE;
          t_start[ars_pkg::TMR_PROVE] = 1'b1; // R19
        end
      ars_pkg::ARS_PROVE:
        if (evt)
        begin
          st_nxt = eligible ? ars_pkg::ARS_ACK : ars_pkg::ARS_IDLE;
          t_stop[ars_pkg::TMR_PROVE] = 1'b1;
        end
        else if (t_done[ars_pkg::TMR_PROVE])
        begin
          succ = 1'b1; // R19
          t_stop[ars_pkg::TMR_WATCH]   = 1'b1; // R10
          t_start[ars_pkg::TMR_WINDOW] = 1'b1; // R13
          if (succ_r >= eff_lim)
            fail_set = 1'b1; // R14
          else
            st_nxt = ars_pkg::ARS_IDLE;
        end
      ars_pkg::ARS_FAIL:
        if (i_manual_ack && !i_motor_on_command)
        begin
          fail_clr = 1'b1; // R14
          st_nxt   = ars_pkg::ARS_IDLE;
        end
      default:
        st_nxt = ars_pkg::ARS_IDLE;
    endcase
    // Watch expiry aborts any sequence in flight
    if (t_done[ars_pkg::TMR_WATCH] && st_r != ars_pkg::ARS_IDLE && st_r != ars_pkg::ARS_FAIL)
      fail_set = 1'b1; // R10
    if (restart_watch_time_r == 16'h0000 || fail_clr)
      t_stop[ars_pkg::TMR_WATCH] = 1'b1; // R11
    if (fail_set)
      st_nxt = ars_pkg::ARS_FAIL;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      st_r <= ars_pkg::ARS_IDLE;
    else
      st_r <= st_nxt;
  end

  // Attempt and success counters; reload causes outrank decrement
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r  <= ars_pkg::LIMIT_RST;
      succ_r <= 8'h00;
    end
    else if (reload_r || fail_clr || t_done[ars_pkg::TMR_WINDOW])
    begin
      cnt_r  <= eff_lim; // R8
      succ_r <= 8'h00;
    end
    else
    begin
      if (ack_go && cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01; // R5
      if (succ)
        succ_r <= succ_r + 8'h01; // R14
    end
  end

  // Outputs toward the inverter; switch-on follows the on command
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_auto_ack     <= 1'b0;
      o_switch_on    <= 1'b0;
      o_restart_fail <= 1'b0;
    end
    else
    begin
      o_auto_ack <= (ack_go && !(restart_mode_sel_r == ars_pkg::MODE_PF_MAN
                                 || restart_mode_sel_r == ars_pkg::MODE_FLT_MAN))
                    || (restart_mode_sel_r == ars_pkg::MODE_ACK_ONLY && evt); // R17
      o_switch_on <= (st_nxt == ars_pkg::ARS_START || st_nxt == ars_pkg::ARS_PROVE)
                     && i_motor_on_command; // R18
      if (fail_set)
        o_restart_fail <= 1'b1; // R6 R7
      else if (fail_clr)
        o_restart_fail <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  mode_off_idle_a: assert property (restart_mode_sel_r == ars_pkg::MODE_OFF && st_r == ars_pkg::ARS_IDLE
    |=> st_r == ars_pkg::ARS_IDLE && !o_auto_ack) else $error("mode zero left idle"); // R1
  dec_on_ack_a: assert property (ack_go && cnt_r != 8'h00 && !reload_r && !fail_clr && !t_done[ars_pkg::TMR_WINDOW]
    |=> cnt_r == $past(cnt_r) - 8'h01) else $error("counter not decremented"); // R5
  reload_cfg_a: assert property (reload_r |=> cnt_r == $past(eff_lim) && succ_r == 8'h00)
    else $error("counter not reloaded"); // R8
  last_fail_a: assert property (st_r == ars_pkg::ARS_ACK && ack_ok && cnt_r == 8'h00
    |=> o_restart_fail && st_r == ars_pkg::ARS_FAIL) else $error("exhausted attempts no fault"); // R7
  watch_off_a: assert property (restart_watch_time_r == 16'h0000 |=> !t_busy[ars_pkg::TMR_WATCH])
    else $error("watch runs at zero"); // R11
  switch_cmd_a: assert property (o_switch_on |-> $past(i_motor_on_command))
    else $error("switch-on without on command"); // R18
  suppress_a: assert property (st_r == ars_pkg::ARS_IDLE && supp |=> st_r == ars_pkg::ARS_IDLE)
    else $error("suppressed fault restarted"); // R16
  fail_hold_a: assert property (o_restart_fail && !(i_manual_ack && !i_motor_on_command)
    |=> o_restart_fail) else $error("fault dropped without ack"); // R14
  no_wait_a: assert property (st_r == ars_pkg::ARS_ACK && st_nxt == ars_pkg::ARS_DELAY
    && restart_mode_sel_r == ars_pkg::MODE_PF_MAN ##1 st_r == ars_pkg::ARS_DELAY [*1]
    |-> ##[1:2] st_r != ars_pkg::ARS_DELAY) else $error("wait applied in manual mode"); // R9

endmodule // ars_supervisor

// file: shared/ars_pkg.sv
package ars_pkg;

  // Clock and time base; all supervisor times count in 100 ms ticks
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int PROVE_MS    = 1000;
  localparam int PROVE_TICKS = PROVE_MS / TICK_MS;
  localparam int DIV_W       = 21;
  localparam int TIME_W      = 16;

  // Restart mode codes
  localparam logic [4:0] MODE_OFF      = 5'h00;
  localparam logic [4:0] MODE_ACK_ONLY = 5'h01;
  localparam logic [4:0] MODE_PF       = 5'h04;
  localparam logic [4:0] MODE_FLT      = 5'h06;
  localparam logic [4:0] MODE_PF_MAN   = 5'h0E;
  localparam logic [4:0] MODE_FLT_MAN  = 5'h10;
  localparam logic [4:0] MODE_ON_CMD   = 5'h1A;

  // Reset values (times in ticks)
  localparam logic [4:0]  MODE_RST   = MODE_OFF;
  localparam logic [7:0]  LIMIT_RST  = 8'h03;
  localparam logic [15:0] WAIT_RST   = 16'h000A;
  localparam logic [15:0] WATCH_RST  = 16'h0258;
  localparam logic [15:0] WINDOW_RST = 16'h0000;

  // Fault numbers
  localparam logic [15:0] FAULT_RESTART_FAIL = 16'h1C98;
  localparam logic [15:0] FAULT_DC_UNDERVOLT = 16'h7533;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_WAIT   = 8'h08;
  localparam logic [7:0] OFS_WATCH  = 8'h0C;
  localparam logic [7:0] OFS_WINDOW = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LIST   = 8'h20;
  localparam int         LIST_N     = 10;

  // Status register field positions
  localparam int ST_CNT_LSB  = 0;
  localparam int ST_SUCC_LSB = 8;
  localparam int ST_BUSY_LSB = 16;
  localparam int ST_STATE_LSB = 24;
  localparam int ST_FAIL_BIT = 31;

  // Timer slots
  localparam int TMR_WAIT   = 0;
  localparam int TMR_WATCH  = 1;
  localparam int TMR_WINDOW = 2;
  localparam int TMR_PROVE  = 3;
  localparam int TMR_N      = 4;

  typedef enum logic [2:0] {ARS_IDLE, ARS_ACK, ARS_DELAY, ARS_START, ARS_PROVE, ARS_FAIL} ars_state_t;

  typedef struct packed {
    logic        fault;
    logic        power_fail;
    logic [15:0] fault_num;
  } ars_evt_t;

endpackage

// file: logic/ars_tick_timer.sv
`timescale 1ns/100ps
module ars_tick_timer
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_tick,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic [15:0] i_load,
  output logic             o_busy,
  output logic             o_done
);

  logic [15:0] cnt_r;

  // Start wins over stop; a load of zero expires on the next cycle
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r  <= 16'h0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_r  <= i_load;
      o_busy <= 1'b1;
      o_done <= 1'b0;
    end
    else if (i_stop)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else if (o_busy && cnt_r == 16'h0000)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b1;
    end
    else
    begin
      o_done <= 1'b0;
      if (o_busy && i_tick)
        cnt_r <= cnt_r - 16'h0001;
    end
  end

endmodule // ars_tick_timer

// file: test/ars_plant.sv
`timescale 1ns/100ps
module ars_plant
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_switch_on,
  input  wire logic         i_fire,
  input  wire logic         i_pf,
  input  wire logic [15:0]  i_num,
  input  wire logic         i_stall,
  output ars_pkg::ars_evt_t o_evt,
  output logic              o_mag
);
  logic [2:0] mag_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Event pulses; the number only means something with the pulse, so it flips otherwise
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      o_evt <= '0;
    else
    begin
      o_evt.fault      <= i_fire;
      o_evt.power_fail <= i_pf;
      o_evt.fault_num  <= i_fire ? i_num : ~o_evt.fault_num;
    end

  // Magnetizing ends three cycles after switch-on; a stall models a motor that never catches
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      mag_r <= '0;
    else if (!i_switch_on)
      mag_r <= '0;
    else if (!i_stall && mag_r != 3'h3)
      mag_r <= mag_r + 3'h1;
  assign o_mag = (mag_r == 3'h3);
endmodule // ars_plant

// file: test/ars_supervisor_bench.sv
`timescale 1ns/100ps
module ars_supervisor_bench;
  typedef struct packed {logic [4:0] m; logic on; logic [1:0] k; logic a; logic s;} ars_case_t;
  localparam logic [15:0] LISTED = 16'h2345;
  localparam logic [7:0] RA[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
  localparam logic [31:0] RV[8] = '{'0, 32'h0000_0003, 32'h0000_000A, 32'h0000_0258, '0, 32'h0000_0003, '0, '0};
  localparam logic [4:0] MC[7] = '{ars_pkg::MODE_OFF, ars_pkg::MODE_ACK_ONLY, ars_pkg::MODE_PF, ars_pkg::MODE_FLT,
                                   ars_pkg::MODE_PF_MAN, ars_pkg::MODE_FLT_MAN, ars_pkg::MODE_ON_CMD};
  localparam ars_case_t CS[13] = '{'{MC[0],1,0,0,0}, '{MC[1],1,0,1,0}, '{MC[1],1,1,1,0}, '{MC[2],1,0,0,0},
    '{MC[2],1,2,1,1}, '{MC[2],1,3,1,1}, '{MC[3],1,1,0,0}, '{MC[3],1,0,1,1}, '{MC[3],0,0,0,0},
    '{MC[4],1,3,0,0}, '{MC[5],1,0,0,0}, '{MC[6],1,1,0,0}, '{MC[6],0,0,1,0}};
  localparam logic [7:0] LIMS[3] = '{8'h00, 8'h01, 8'h03};
  logic i_mclk = 0, i_rst = 1, hsel = 0, hwrite = 0, hready, hresp, rd_dp = 0;
  logic motor_on = 1, man_ack = 0, fire = 0, pf = 0, stall = 0, mag, auto_ack, sw_on, rfail;
  logic [1:0] htrans = '0;
  logic [15:0] num = '0, n;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, lfsr_r = 32'h0001_4A4F;
  logic [31:0] exp_q[$], msk_q[$];
  ars_pkg::ars_evt_t evt;
  int failures = 0, check_count = 0, ack_cnt = 0, sw_cnt = 0, cyc = 0, a0, s0, mx;

  ars_supervisor #(.TICK_CYCLES(4)) ars_supervisor_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_evt(evt), .i_motor_on_command(motor_on),
    .i_manual_ack(man_ack), .i_magnetization_done_flag(mag), .o_auto_ack(auto_ack), .o_switch_on(sw_on),
    .o_restart_fail(rfail));
  ars_plant ars_plant_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_switch_on(sw_on), .i_fire(fire), .i_pf(pf),
    .i_num(num), .i_stall(stall), .o_evt(evt), .o_mag(mag));

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  always #25 i_mclk = ~i_mclk;

  // Read data is judged at the edge that ends its data phase, against the oldest note
  always @(posedge i_mclk)
  begin
    if (rd_dp && hready === 1'b1)
    begin
      check("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
      check("hresp", 32'(hresp), '0);
    end
    if (hready === 1'b1)
      rd_dp = hsel & htrans[1] & ~hwrite;
  end

  // Pulse and level counters; the cycle ceiling cuts a hang short
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    ack_cnt <= ack_cnt + (auto_ack === 1'b1);
    sw_cnt <= sw_cnt + (sw_on === 1'b1);
    if (cyc > 20000)
    begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Address phase held until taken, data phase until hready returns
  // Select stays high after a call, so back-to-back calls never toggle it in one step
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hsel <= 1'b1;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'b0, '0);
  endtask

  task automatic hit(input logic [15:0] v, input logic f, input logic p);
    num <= v;
    fire <= f;
    pf <= p;
    @(posedge i_mclk);
    fire <= 1'b0;
    pf <= 1'b0;
  endtask

  task automatic op_ack();
    man_ack <= 1'b1;
    @(posedge i_mclk);
    man_ack <= 1'b0;
  endtask

  function automatic logic [15:0] next_num();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return {4'h1, lfsr_r[11:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    foreach (RV[i]) rd(RA[i], RV[i]);
    // Every mode code is kept, then random wait times
    foreach (MC[i])
    begin
      bus(ars_pkg::OFS_MODE, 1'b1, 32'(MC[i]));
      rd(ars_pkg::OFS_MODE, 32'(MC[i]));
    end
    repeat (3)
    begin
      n = next_num();
      bus(ars_pkg::OFS_WAIT, 1'b1, 32'(n));
      rd(ars_pkg::OFS_WAIT, 32'(n));
    end
    // Short wait, long default watch time keeps the watch above the start-up sum
    bus(ars_pkg::OFS_WAIT, 1'b1, 32'h0000_0001);
    bus(ars_pkg::OFS_LIST, 1'b1, 32'(LISTED));
    // Acknowledge and switch-on per mode, list and event kind
    foreach (CS[i])
    begin
      bus(ars_pkg::OFS_MODE, 1'b1, 32'(CS[i].m));
      motor_on <= CS[i].on;
      a0 = ack_cnt;
      s0 = sw_cnt;
      n = (CS[i].k == 2'h1) ? LISTED : (CS[i].k == 2'h2) ? ars_pkg::FAULT_DC_UNDERVOLT : next_num();
      hit(n, CS[i].k != 2'h3, CS[i].k == 2'h3);
      repeat (30) @(posedge i_mclk);
      check("auto_ack", 32'(ack_cnt - a0), 32'(CS[i].a));
      check("switch_on", 32'(sw_cnt != s0), 32'(CS[i].s));
      motor_on <= 1'b1;
      op_ack();
      repeat (150) @(posedge i_mclk);
    end
    // Faults inside the proving second use up the attempts
    foreach (LIMS[i])
    begin
      mx = (LIMS[i] > 1) ? LIMS[i] : 1;
      bus(ars_pkg::OFS_LIMIT, 1'b1, 32'(LIMS[i]));
      bus(ars_pkg::OFS_MODE, 1'b1, 32'(ars_pkg::MODE_ON_CMD));
      for (int j = 0; j <= mx; j++)
      begin
        check("restart_fail", 32'(rfail), '0);
        hit(next_num(), 1'b1, 1'b0);
        repeat (4) @(posedge i_mclk);
        if (j < mx)
          rd(ars_pkg::OFS_STATUS, 32'(mx - 1 - j), 32'h0000_00FF);
        repeat (26) @(posedge i_mclk);
      end
      check("restart_fail", 32'(rfail), 32'h0000_0001);
      motor_on <= 1'b0;
      op_ack();
      repeat (4) @(posedge i_mclk);
      check("restart_fail", 32'(rfail), '0);
      rd(ars_pkg::OFS_STATUS, 32'(mx), 32'h0000_00FF);
      motor_on <= 1'b1;
      repeat (20) @(posedge i_mclk);
    end
    // No switch-on before the wait time of eight ticks has run
    bus(ars_pkg::OFS_WAIT, 1'b1, 32'h0000_0008);
    s0 = sw_cnt;
    hit(next_num(), 1'b1, 1'b0);
    repeat (26) @(posedge i_mclk);
    check("switch_on", 32'(sw_cnt != s0), '0);
    repeat (30) @(posedge i_mclk);
    check("switch_on", 32'(sw_cnt != s0), 32'h0000_0001);
    repeat (100) @(posedge i_mclk);
    // A second restart inside a long counter-reset window with a limit of one is refused
    bus(ars_pkg::OFS_WINDOW, 1'b1, 32'h0000_00C8);
    bus(ars_pkg::OFS_LIMIT, 1'b1, 32'h0000_0001);
    for (int j = 0; j < 2; j++)
    begin
      check("restart_fail", 32'(rfail), '0);
      hit(next_num(), 1'b1, 1'b0);
      repeat (120) @(posedge i_mclk);
    end
    check("restart_fail", 32'(rfail), 32'h0000_0001);
    motor_on <= 1'b0;
    op_ack();
    motor_on <= 1'b1;
    // A motor that never magnetizes: watch of two ticks fails, watch of zero never does
    stall <= 1'b1;
    for (int w = 2; w >= 0; w -= 2)
    begin
      bus(ars_pkg::OFS_WATCH, 1'b1, 32'(w));
      hit(next_num(), 1'b1, 1'b0);
      repeat (80) @(posedge i_mclk);
      check("restart_fail", 32'(rfail), 32'(w != 0));
      motor_on <= 1'b0;
      op_ack();
      motor_on <= 1'b1;
    end
    print_verdict();
  end
endmodule // ars_supervisor_bench
